// *** hdl/fast_detect_defines.vh ***
// Register map, field positions and reset values of the overrange detect block
`ifndef FAST_DETECT_DEFINES_VH
`define FAST_DETECT_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_DETECT_PIN_CONTROL  12'h0245
`define ADDR_UPPER_THRESHOLD_LOW 12'h0247
`define ADDR_UPPER_THRESHOLD_HIGH 12'h0248
`define ADDR_LOWER_THRESHOLD_LOW 12'h0249
`define ADDR_LOWER_THRESHOLD_HIGH 12'h024A
`define ADDR_DWELL_COUNT_LOW     12'h024B
`define ADDR_DWELL_COUNT_HIGH    12'h024C
`define ADDR_MONITOR_SYNC_CONTROL 12'h026F
`define ADDR_IRQ_STATUS          12'h0280
`define ADDR_IRQ_MASK            12'h0281

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_DETECT_ENABLE        0
`define BIT_FORCE_VALUE          2
`define BIT_FORCE_ENABLE         3
`define BIT_SYNC_ENABLE          0
`define BIT_SYNC_NEXT_MODE       1
`define BIT_IRQ_FLAG_SET         0
`define BIT_IRQ_FLAG_CLEAR       1
`define BIT_IRQ_SYNC_DONE        2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_REG8                 8'h00
`define RST_IRQ3                 3'h0
`define RST_DWELL                16'h0000

`endif

// *** hdl/dwell_timer.v ***
// Dwell counter that measures how long the magnitude stays at or below the lower threshold
`timescale 1ns/1ps
`default_nettype none
`include "fast_detect_defines.vh"

module dwell_timer (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Control
  input wire restart,
  input wire [15:0] load_value,
  // Status
  output reg expired
);

  reg [15:0] count_q;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Restart reloads; counting down to zero marks the dwell as served
  always @(posedge clk) begin
    if (srst) begin
      count_q <= `RST_DWELL;
      expired <= 1'b0;
    end else if (restart) begin
      count_q <= load_value;
      expired <= 1'b0;
    end else if (count_q != 16'h0000) begin
      count_q <= count_q - 16'h0001;
      expired <= (count_q == 16'h0001);
    end else begin
      expired <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// *** hdl/fast_detect_monitor.v ***
// Overrange detect pin logic with thresholds, dwell, forcing and monitor sync control
// Notes on behaviour
// - With the force bit set the detect pin takes the software value, otherwise it follows detection.
// - While forced, the detect pin equals the force value bit of the control register.
// - The enable bit switches threshold detection off at 0 and on at 1.
// - The magnitude is compared with a 13-bit upper threshold split into 8 low and 5 high bits.
// - The magnitude is compared with a 13-bit lower threshold split the same way.
// - With detection enabled, the pin drops to 0 only after the data stays at or below the lower threshold for the 16-bit dwell count.
// - Sync mode bit 0 resynchronises on every reference edge; 1 uses only the next edge.
// - In next-edge mode the sync enable bit clears itself once the edge is captured.
// - The sync enable bit gates all alignment, which also needs the reference input enabled.
`timescale 1ns/1ps
`default_nettype none
`include "fast_detect_defines.vh"

module fast_detect_monitor (
  // Clock and reset
  input wire I_CLK,
  input wire I_SRST,
  // Register port
  input wire [11:0] I_ADDR,
  input wire [7:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [7:0] O_RDATA,
  // Converter data path
  input wire [12:0] I_FINE_MAG,
  // Reference input
  input wire I_SYSREF,
  input wire I_SYSREF_ENABLE,
  // Outputs
  output reg O_OVERRANGE_FLAG_PIN,
  output reg O_MONITOR_ALIGN,
  output reg O_IRQ
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] ctrl_q;
  reg [7:0] up_lo_q;
  reg [4:0] up_hi_q;
  reg [7:0] lo_lo_q;
  reg [4:0] lo_hi_q;
  reg [7:0] dw_lo_q;
  reg [7:0] dw_hi_q;
  reg [1:0] sync_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_mask_q;
  reg detect_q;
  reg sref_m_q;
  reg sref_s_q;
  reg sref_d_q;
  reg sref_en_m_q;
  reg sref_en_s_q;

  wire [12:0] upper_thr = {up_hi_q, up_lo_q};
  wire [12:0] lower_thr = {lo_hi_q, lo_lo_q};
  wire [15:0] dwell_load = {dw_hi_q, dw_lo_q};
  wire above_upper = (I_FINE_MAG > upper_thr);
  wire above_lower = (I_FINE_MAG > lower_thr);
  wire det_en = ctrl_q[`BIT_DETECT_ENABLE];
  wire dwell_done;
  wire dwell_restart = ~det_en | above_lower;

  // ----------------------------------------
  // Reference synchroniser and edge detect
  // ----------------------------------------
  // Pins are asynchronous: two flops before any logic looks at them
  always @(posedge I_CLK) begin
    if (I_SRST) begin
      sref_m_q <= 1'b0;
      sref_s_q <= 1'b0;
      sref_d_q <= 1'b0;
      sref_en_m_q <= 1'b0;
      sref_en_s_q <= 1'b0;
    end else begin
      sref_m_q <= I_SYSREF;
      sref_s_q <= sref_m_q;
      sref_d_q <= sref_s_q;
      sref_en_m_q <= I_SYSREF_ENABLE;
      sref_en_s_q <= sref_en_m_q;
    end
  end

  wire sref_rise = sref_s_q & ~sref_d_q;
  // Alignment only with sync enabled and the reference input enabled
  wire align_now = sref_rise & sref_en_s_q & sync_q[`BIT_SYNC_ENABLE];
  // Continuous mode relies on the reference period being a multiple of the monitor period
  wire next_done = align_now & sync_q[`BIT_SYNC_NEXT_MODE];

  // ----------------------------------------
  // Dwell counter
  // ----------------------------------------
  dwell_timer u_dwell (
    .clk(I_CLK),
    .srst(I_SRST),
    .restart(dwell_restart),
    .load_value(dwell_load),
    .expired(dwell_done)
  );

  // ----------------------------------------
  // Detection state
  // ----------------------------------------
  // Raised at once over the upper threshold; while enabled, released only after the dwell, cleared at once when disabled
  always @(posedge I_CLK) begin
    if (I_SRST) begin
      detect_q <= 1'b0;
    end else if (!det_en) begin
      detect_q <= 1'b0;
    end else if (above_upper) begin
      detect_q <= 1'b1;
    end else if (dwell_done && !above_lower) begin
      detect_q <= 1'b0;
    end
  end

  wire det_rise = det_en & above_upper & ~detect_q;
  wire det_fall = det_en & detect_q & ~above_upper & dwell_done & ~above_lower;

  // ----------------------------------------
  // Output pin and align pulse
  // ----------------------------------------
  // Forcing overrides even a disabled detector, so the pin can be tested alone
  always @(posedge I_CLK) begin
    if (I_SRST) begin
      O_OVERRANGE_FLAG_PIN <= 1'b0;
      O_MONITOR_ALIGN <= 1'b0;
    end else begin
      if (ctrl_q[`BIT_FORCE_ENABLE]) begin
        O_OVERRANGE_FLAG_PIN <= ctrl_q[`BIT_FORCE_VALUE];
      end else begin
        O_OVERRANGE_FLAG_PIN <= detect_q;
      end
      O_MONITOR_ALIGN <= align_now;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Hardware clear of the sync enable wins over a same-cycle software write
  always @(posedge I_CLK) begin
    if (I_SRST) begin
      ctrl_q <= `RST_REG8;
      up_lo_q <= `RST_REG8;
      up_hi_q <= 5'h00;
      lo_lo_q <= `RST_REG8;
      lo_hi_q <= 5'h00;
      dw_lo_q <= `RST_REG8;
      dw_hi_q <= `RST_REG8;
      sync_q <= 2'h0;
      irq_mask_q <= `RST_IRQ3;
    end else begin
      if (I_WR) begin
        if (I_ADDR == `ADDR_DETECT_PIN_CONTROL) begin
          ctrl_q <= {4'h0, I_WDATA[3:2], 1'b0, I_WDATA[0]};
        end else if (I_ADDR == `ADDR_UPPER_THRESHOLD_LOW) begin
          up_lo_q <= I_WDATA;
        end else if (I_ADDR == `ADDR_UPPER_THRESHOLD_HIGH) begin
          up_hi_q <= I_WDATA[4:0];
        end else if (I_ADDR == `ADDR_LOWER_THRESHOLD_LOW) begin
          lo_lo_q <= I_WDATA;
        end else if (I_ADDR == `ADDR_LOWER_THRESHOLD_HIGH) begin
          lo_hi_q <= I_WDATA[4:0];
        end else if (I_ADDR == `ADDR_DWELL_COUNT_LOW) begin
          dw_lo_q <= I_WDATA;
        end else if (I_ADDR == `ADDR_DWELL_COUNT_HIGH) begin
          dw_hi_q <= I_WDATA;
        end else if (I_ADDR == `ADDR_MONITOR_SYNC_CONTROL) begin
          sync_q <= I_WDATA[1:0];
        end else if (I_ADDR == `ADDR_IRQ_MASK) begin
          irq_mask_q <= I_WDATA[2:0];
        end
      end
      if (next_done) begin
        sync_q[`BIT_SYNC_ENABLE] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  // Sticky flags, write one to clear; a new event in the clear cycle is kept
  wire [2:0] irq_events = {next_done, det_fall, det_rise};
  wire [2:0] irq_clear = (I_WR && I_ADDR == `ADDR_IRQ_STATUS) ? I_WDATA[2:0] : 3'h0;

  always @(posedge I_CLK) begin
    if (I_SRST) begin
      irq_stat_q <= `RST_IRQ3;
      O_IRQ <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clear) | irq_events;
      O_IRQ <= |(((irq_stat_q & ~irq_clear) | irq_events) & irq_mask_q);
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // Data stand one cycle after the read strobe; unmapped offsets read zero
  always @(posedge I_CLK) begin
    if (I_SRST) begin
      O_RDATA <= `RST_REG8;
    end else if (I_RD) begin
      if (I_ADDR == `ADDR_DETECT_PIN_CONTROL) begin
        O_RDATA <= ctrl_q;
      end else if (I_ADDR == `ADDR_UPPER_THRESHOLD_LOW) begin
        O_RDATA <= up_lo_q;
      end else if (I_ADDR == `ADDR_UPPER_THRESHOLD_HIGH) begin
        O_RDATA <= {3'h0, up_hi_q};
      end else if (I_ADDR == `ADDR_LOWER_THRESHOLD_LOW) begin
        O_RDATA <= lo_lo_q;
      end else if (I_ADDR == `ADDR_LOWER_THRESHOLD_HIGH) begin
        O_RDATA <= {3'h0, lo_hi_q};
      end else if (I_ADDR == `ADDR_DWELL_COUNT_LOW) begin
        O_RDATA <= dw_lo_q;
      end else if (I_ADDR == `ADDR_DWELL_COUNT_HIGH) begin
        O_RDATA <= dw_hi_q;
      end else if (I_ADDR == `ADDR_MONITOR_SYNC_CONTROL) begin
        O_RDATA <= {6'h00, sync_q};
      end else if (I_ADDR == `ADDR_IRQ_STATUS) begin
        O_RDATA <= {5'h00, irq_stat_q};
      end else if (I_ADDR == `ADDR_IRQ_MASK) begin
        O_RDATA <= {5'h00, irq_mask_q};
      end else begin
        O_RDATA <= 8'h00;
      end
    end else begin
      O_RDATA <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// *** sim/fast_detect_monitor_properties.sv ***
// Port-level assertions for the overrange detect block
`timescale 1ns/1ps
`default_nettype none
module fast_detect_monitor_properties (
  input wire logic I_CLK, I_SRST, I_WR, I_RD, I_SYSREF, I_SYSREF_ENABLE,
  input wire logic [11:0] I_ADDR,
  input wire logic [7:0] I_WDATA, O_RDATA,
  input wire logic [12:0] I_FINE_MAG,
  input wire logic O_OVERRANGE_FLAG_PIN, O_MONITOR_ALIGN, O_IRQ
);
  logic [7:0] ctl_q;
  logic [12:0] up_q, lo_q;
  logic [15:0] dw_q;
  logic [16:0] below_q;
  logic [1:0] act_q;
  logic armed_q, next_q;
  wire pin = O_OVERRANGE_FLAG_PIN;
  // Mirror of written fields, so thresholds and modes are known at each edge
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      {ctl_q, up_q, lo_q, dw_q, below_q, act_q, armed_q, next_q} <= '0;
    end else begin
      if (I_WR) begin
        case (I_ADDR)
          12'h0245: ctl_q <= I_WDATA & 8'h0D;
          12'h0247: up_q[7:0] <= I_WDATA;
          12'h0248: up_q[12:8] <= I_WDATA[4:0];
          12'h0249: lo_q[7:0] <= I_WDATA;
          12'h024A: lo_q[12:8] <= I_WDATA[4:0];
          12'h024B: dw_q[7:0] <= I_WDATA;
          12'h024C: dw_q[15:8] <= I_WDATA;
          12'h026F: {next_q, armed_q} <= I_WDATA[1:0];
          default: ;
        endcase
      end
      // A one-shot arm is spent by its alignment, even against a write
      if (O_MONITOR_ALIGN && next_q) armed_q <= 1'b0;
      // Saturating run of samples at or below the lower threshold
      below_q <= (I_FINE_MAG > lo_q) ? 17'h0_0000 : below_q + {16'h0000, ~&below_q};
      act_q <= {act_q[0], ctl_q[0] | ctl_q[3]};
    end
  end
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  sequence s_over;
    ctl_q[0] && !ctl_q[3] && I_FINE_MAG > up_q;
  endsequence
  sequence s_free;
    !ctl_q[3];
  endsequence
  a_rise_on_upper: assert property (s_over ##1 s_free |-> ##1 pin)
    else $error("pin did not rise");
  a_force_value: assert property ($past(ctl_q[3]) |-> pin == $past(ctl_q[2]))
    else $error("forced pin wrong");
  a_disabled_low: assert property (act_q == 2'b00 |-> !pin)
    else $error("pin high while off");
  a_dwell_hold: assert property ($fell(pin) && $past(ctl_q, 2) == 8'h01 && $past(ctl_q) == 8'h01
    |-> $past(below_q) >= {1'b0, dw_q}) else $error("pin fell early");
  a_dwell_release: assert property (below_q == {1'b0, dw_q} + 17'h0_0006 && ctl_q == 8'h01
    && $stable(ctl_q) |-> !pin) else $error("pin held too long");
  a_ctl_readback: assert property (I_RD && I_ADDR == 12'h0245 |=> O_RDATA == $past(ctl_q))
    else $error("control readback");
  a_upper_readback: assert property (I_RD && I_ADDR == 12'h0248 |=> O_RDATA == {3'b000, $past(up_q[12:8])})
    else $error("upper readback");
  a_lower_readback: assert property (I_RD && I_ADDR == 12'h0249 |=> O_RDATA == $past(lo_q[7:0]))
    else $error("lower readback");
  a_align_armed: assert property (O_MONITOR_ALIGN |-> $past(armed_q))
    else $error("align while not armed");
endmodule
bind fast_detect_monitor fast_detect_monitor_properties u_props (.I_CLK, .I_SRST, .I_WR, .I_RD, .I_SYSREF,
  .I_SYSREF_ENABLE, .I_ADDR, .I_WDATA, .O_RDATA, .I_FINE_MAG, .O_OVERRANGE_FLAG_PIN, .O_MONITOR_ALIGN, .O_IRQ);
`default_nettype wire

// *** sim/agc_partner.sv ***
// Gain-control logic model: watches the detect pin and paces the reference
`timescale 1ns/1ps
`default_nettype none
module agc_partner #(parameter int MON_PERIOD = 8) (
  input wire logic clk, srst, run, pin,
  output logic sysref,
  output logic [7:0] rises
);
  logic [7:0] tick_q;
  logic pin_q;
  // Reference period is four monitor periods, so alignment never drifts; idle low
  always_ff @(posedge clk) begin
    if (srst || !run) tick_q <= 8'h00;
    else tick_q <= (tick_q == 8'(4 * MON_PERIOD - 1)) ? 8'h00 : tick_q + 8'h01;
    sysref <= run && tick_q < 8'(MON_PERIOD);
    pin_q <= pin;
    if (srst) rises <= 8'h00;
    else if (pin && !pin_q) rises <= rises + 8'h01;
  end
endmodule
`default_nettype wire

// *** sim/test_fast_detect_monitor.sv ***
// Self-checking bench for the overrange detect block
`timescale 1ns/1ps
`default_nettype none
module test_fast_detect_monitor;
  logic I_CLK = 1'b0, I_SRST = 1'b1, I_WR = 1'b0, I_RD = 1'b0, I_SYSREF_ENABLE = 1'b1, run = 1'b0;
  logic [11:0] I_ADDR = 12'h0000;
  logic [7:0] I_WDATA = 8'h00;
  logic [12:0] I_FINE_MAG = 13'h0000;
  wire [7:0] O_RDATA, rises;
  wire O_OVERRANGE_FLAG_PIN, O_MONITOR_ALIGN, O_IRQ, sysref;
  int err_count = 0, samples_checked = 0, n;
  logic [11:0] ad [8] = '{12'h0245, 12'h0247, 12'h0248, 12'h0249, 12'h024A, 12'h024B, 12'h024C, 12'h026F};
  logic [7:0] mk [8] = '{8'h0D, 8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'h03};
  fast_detect_monitor DUT (.I_CLK, .I_SRST, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_FINE_MAG,
    .I_SYSREF(sysref), .I_SYSREF_ENABLE, .O_OVERRANGE_FLAG_PIN, .O_MONITOR_ALIGN, .O_IRQ);
  agc_partner u_agc (.clk(I_CLK), .srst(I_SRST), .run(run), .pin(O_OVERRANGE_FLAG_PIN), .sysref, .rises);
  initial forever #10 I_CLK = ~I_CLK;
  // Shared bus cycles and comparison
  task automatic chk(input string s, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge I_CLK) {I_WR, I_ADDR, I_WDATA} <= {1'b1, a, d};
    @(posedge I_CLK) I_WR <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge I_CLK) {I_RD, I_ADDR} <= {1'b1, a};
    @(posedge I_CLK) I_RD <= 1'b0;
    #1 chk("rdata", e, O_RDATA);
  endtask
  task automatic mag(input logic [12:0] v);
    @(posedge I_CLK) I_FINE_MAG <= v;
  endtask
  task automatic cyc(input int k, input logic e);
    repeat (k) @(posedge I_CLK);
    #1 chk("pin", e, O_OVERRANGE_FLAG_PIN);
  endtask
  // Bounded wait on the interrupt (q set) or the pin; running out ends the run
  task automatic wt(input logic q, input logic e);
    #1 n = 0;
    while ((q ? O_IRQ : O_OVERRANGE_FLAG_PIN) !== e && n < 12) begin @(posedge I_CLK); #1 n++; end
    chk(q ? "irq" : "pin", e, q ? O_IRQ : O_OVERRANGE_FLAG_PIN);
    if (n == 12 && (q ? O_IRQ : O_OVERRANGE_FLAG_PIN) !== e) complete_run();
  endtask
  task automatic complete_run;
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Reset values, writable bits, unmapped place
  task automatic t_regs;
    for (int i = 0; i < 8; i++) rd(ad[i], 8'h00);
    for (int i = 0; i < 8; i++) begin wr(ad[i], 8'hFF); rd(ad[i], mk[i]); wr(ad[i], 8'h00); end
    wr(12'h0300, 8'hFF); rd(12'h0300, 8'h00);
  endtask
  // Upper 0x1234, lower 0x0100, dwell five; interrupt raised, masked, cleared
  task automatic t_detect;
    wr(12'h0247, 8'h34); wr(12'h0248, 8'h12); wr(12'h0249, 8'h00); wr(12'h024A, 8'h01);
    wr(12'h024B, 8'h05); wr(12'h024C, 8'h00); wr(12'h0281, 8'h01); wr(12'h0280, 8'h07); wr(12'h0245, 8'h01);
    mag(13'h1234); cyc(4, 1'b0);
    mag(13'h1235); cyc(2, 1'b1);
    wt(1'b1, 1'b1); rd(12'h0280, 8'h01); wr(12'h0280, 8'h01); wt(1'b1, 1'b0);
    mag(13'h0101); cyc(12, 1'b1);
    mag(13'h0100); cyc(3, 1'b1); mag(13'h0101); mag(13'h0100); cyc(5, 1'b1);
    wt(1'b0, 1'b0);
    chk("irq", 1'b0, O_IRQ); rd(12'h0280, 8'h02); wr(12'h0281, 8'h02); wt(1'b1, 1'b1);
    wr(12'h0280, 8'h02); wt(1'b1, 1'b0); chk("rises", 8'h02, rises);
    mag(13'h1FFF); cyc(2, 1'b1); wr(12'h0245, 8'h00); cyc(2, 1'b0); cyc(4, 1'b0);
    wr(12'h0245, 8'h0C); cyc(1, 1'b1); wr(12'h0245, 8'h08); cyc(1, 1'b0);
    wr(12'h0245, 8'h09); cyc(3, 1'b0); wr(12'h0245, 8'h01); cyc(1, 1'b1);
  endtask
  // Count alignments over 200 cycles; above four stands for continuous
  task automatic al(input logic [7:0] sc, input int e, input logic [7:0] rb);
    wr(12'h026F, sc);
    n = 0;
    repeat (200) begin @(posedge I_CLK); #1 n += O_MONITOR_ALIGN; end
    chk("aligns", e, (n > 4 && e > 4) ? e : n);
    rd(12'h026F, rb);
  endtask
  task automatic t_sync;
    @(posedge I_CLK) run <= 1'b1;
    al(8'h03, 1, 8'h02);
    rd(12'h0280, 8'h05);
    al(8'h01, 5, 8'h01);
    al(8'h00, 0, 8'h00);
    @(posedge I_CLK) I_SYSREF_ENABLE <= 1'b0;
    al(8'h01, 0, 8'h01);
  endtask
  initial begin
    repeat (16) @(posedge I_CLK);
    I_SRST <= 1'b0;
    t_regs();
    t_detect();
    t_sync();
    complete_run();
  end
endmodule
`default_nettype wire
